// ==== sdc_pkg.sv ====
// shared constants for the step/direction input conditioner
package sdc_pkg;
  localparam int          NUM_INPUTS       = 5;
  localparam logic [7:0]  MODE_STEP_DIR    = 8'hFF;
  localparam logic [7:0]  MODE_AUTO_SETUP  = 8'hFE;
  localparam logic [4:0]  ADDR_SPECIAL_EN  = 5'h00;
  localparam logic [4:0]  ADDR_INVERT      = 5'h01;
  localparam logic [4:0]  ADDR_FORCE_EN    = 5'h02;
  localparam logic [4:0]  ADDR_FORCE_VAL   = 5'h03;
  localparam logic [4:0]  ADDR_RAW         = 5'h04;
  localparam logic [4:0]  ADDR_THRESH      = 5'h05;
  localparam logic [4:0]  ADDR_SUMMARY     = 5'h06;
  localparam logic [4:0]  ADDR_MODE        = 5'h07;
  localparam logic [4:0]  ADDR_CONTROL     = 5'h08;
  localparam logic [4:0]  ADDR_STATUS      = 5'h09;
  localparam logic [4:0]  ADDR_NUMER       = 5'h0A;
  localparam logic [4:0]  ADDR_DENOM       = 5'h0B;
  localparam logic [4:0]  ADDR_SUBMODE     = 5'h0C;
  localparam logic [4:0]  ADDR_ERR_WINDOW  = 5'h0D;
  localparam logic [4:0]  ADDR_ERR_TIMEOUT = 5'h0E;
  localparam logic [4:0]  ADDR_ROUTE_EN    = 5'h0F;
  localparam logic [4:0]  ADDR_POSITION    = 5'h10;
  localparam logic [4:0]  ADDR_ACTUAL_POS  = 5'h11;
  localparam int          LEVEL_BASE       = 16;
  localparam int          CTRL_START_BIT   = 4;
  localparam int          STAT_INDEX_BIT   = 10;
  localparam int          STAT_ALIGNED_BIT = 12;
  localparam int          STAT_FOLLOW_BIT  = 13;
  localparam logic [31:0] NUMER_RESET      = 32'h0000_0080;
  localparam logic [31:0] DENOM_RESET      = 32'h0000_0001;
  localparam logic [31:0] SPECIAL_EN_RESET = 32'h0000_0000;
  localparam int          CLK_HZ           = 50_000_000;
  localparam int          MS_CYCLES        = CLK_HZ / 1000;
  localparam int          SETUP_MS         = 2;
  localparam int          SETUP_CYCLES     = SETUP_MS * MS_CYCLES;
  typedef enum logic [1:0] {SETUP_IDLE, SETUP_RUN, SETUP_DONE} setup_state_t;
endpackage

// ==== step_if.sv ====
// step event bundle between the edge detector and the main block
`timescale 1ns/100ps
`default_nettype none
interface step_if;
  logic step;
  logic dir_neg;
  modport src (output step, output dir_neg);
  modport dst (input  step, input  dir_neg);
endinterface
`default_nettype wire

// ==== step_pulse_decoder.sv ====
// turns synchronised clock/direction levels into step events
`timescale 1ns/100ps
`default_nettype none
module step_pulse_decoder
  import sdc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic submode,
  input  wire logic line_a,
  input  wire logic line_b,
  step_if.src       ev
);
  logic a_q;
  logic b_q;
  wire  rise_a = line_a & ~a_q;
  wire  rise_b = line_b & ~b_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= line_a;
      b_q <= line_b;
    end
  end
  // submode 0: pulse on a, sense from level of b; 1: one line per sense
  assign ev.step    = enable & (submode ? (rise_a | rise_b) : rise_a); // see RL7 RL8
  assign ev.dir_neg = submode ? rise_b : line_b; // see RL7 RL8
endmodule
`default_nettype wire

// ==== auto_setup_seq.sv ====
// auto-setup start handshake and completion flags
`timescale 1ns/100ps
`default_nettype none
module auto_setup_seq
  import sdc_pkg::*;
#(
  parameter int RUN_CYCLES = SETUP_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  active,
  input  wire logic  start_bit,
  input  wire logic  index_seen,
  output logic       indexed,
  output logic       aligned
);
  if (RUN_CYCLES < 1) begin
    $error("RUN_CYCLES must be positive");
  end
  setup_state_t state_q;
  logic         start_q;
  logic [31:0]  cnt_q;
  wire          start_edge = active & start_bit & ~start_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SETUP_IDLE;
      start_q <= 1'b0;
      cnt_q   <= 32'h0000_0000;
      indexed <= 1'b0;
      aligned <= 1'b0;
    end else begin
      start_q <= start_bit;
      unique case (state_q)
        SETUP_IDLE: begin
          if (start_edge) begin // see RL10
            state_q <= SETUP_RUN;
            cnt_q   <= 32'h0000_0000;
            indexed <= 1'b0;
            aligned <= 1'b0;
          end
        end
        SETUP_RUN: begin
          if (index_seen) indexed <= 1'b1; // see RL11
          if (!active) begin
            state_q <= SETUP_IDLE;
          end else if (cnt_q == 32'(RUN_CYCLES - 1)) begin
            state_q <= SETUP_DONE;
            aligned <= 1'b1; // see RL12
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        SETUP_DONE: begin
          if (start_edge) begin
            state_q <= SETUP_RUN;
            cnt_q   <= 32'h0000_0000;
            indexed <= 1'b0;
            aligned <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== step_dir_input_conditioner.sv ====
// input conditioning, clock/direction stepping and register file
//
// Functional notes
// RL1: mode selector FF enters clock/direction stepping.
// RL2: one scaled step per clock pulse, direction from the direction signal.
// RL3: far side keeps pulses at most 1 MHz, high at least 200 ns.
// RL4: step width is numerator over denominator, default 128 over 1.
// RL5: far side waits 35 us after a direction change before pulsing.
// RL6: status bit 13 set when tracking error exceeds window past timeout.
// RL7: submode 0 counts pulses on input 1, sense from input 2 level.
// RL8: submode 1 takes sense from which input receives the pulses.
// RL9: mode selector FE enters auto-setup.
// RL10: auto-setup starts only on a rising edge of control bit 4.
// RL11: status bit 10 shows whether an index pulse was seen.
// RL12: status bit 12 rises when auto-setup finishes.
// RL13: each input has a special bit (0..15) and level bit (16..31).
// RL14: input n level sits at bit 15+n regardless of the enable mask.
// RL15: enable mask gates special bits only, never level bits.
// RL16: special bits 0,1,2 are negative limit, positive limit, home.
// RL17: inputs 1,2,3 carry special functions; inputs 4,5 have none.
// RL18: invert bit set makes a high pin read 0; not for clock/direction.
// RL19: force enable replaces the pin value by the force value.
// RL20: raw word shows unmodified pin levels.
// RL21: threshold bit 0 selects 5 V, 1 selects 24 V, bit 0 is input 1.
// RL22: routing enable 1 makes enable, invert and force settings inert.
// RL23: order is force select, then invert, then special-bit gating.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module step_dir_input_conditioner
  import sdc_pkg::*;
#(
  parameter int N_IN       = NUM_INPUTS,
  parameter int RUN_CYCLES = SETUP_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic [N_IN-1:0]   pin_in,
  input  wire logic              index_pulse,
  input  wire logic [31:0]       actual_position,
  input  wire logic [4:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr_stb,
  input  wire logic              rd_stb,
  output logic      [31:0]       rdata,
  output logic      [N_IN-1:0]   threshold_24v,
  output logic                   neg_limit,
  output logic                   pos_limit,
  output logic                   home_switch,
  output logic      [31:0]       step_position
);
  if (N_IN < 3 || N_IN > 16) begin
    $error("N_IN must be 3 to 16");
  end

  // reset release
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // pin synchronisers
  logic [N_IN-1:0] pin_s1_q;
  logic [N_IN-1:0] pin_s2_q;
  logic            idx_s1_q;
  logic            idx_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      idx_s1_q <= 1'b0;
      idx_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      idx_s1_q <= index_pulse;
      idx_s2_q <= idx_s1_q;
    end
  end

  // registers
  logic [31:0] special_en_q;
  logic [31:0] invert_q;
  logic [31:0] force_en_q;
  logic [31:0] force_val_q;
  logic [31:0] thresh_q;
  logic [7:0]  mode_q;
  logic [31:0] control_q;
  logic [31:0] numer_q;
  logic [31:0] denom_q;
  logic        submode_q;
  logic [31:0] err_window_q;
  logic [31:0] err_timeout_q;
  logic        route_en_q;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
    return a == r;
  endfunction

  // write decode
  wire special_wr   = wr_stb & hit(addr, ADDR_SPECIAL_EN);
  wire invert_wr    = wr_stb & hit(addr, ADDR_INVERT);
  wire force_en_wr  = wr_stb & hit(addr, ADDR_FORCE_EN);
  wire force_val_wr = wr_stb & hit(addr, ADDR_FORCE_VAL);
  wire thresh_wr    = wr_stb & hit(addr, ADDR_THRESH);
  wire mode_wr      = wr_stb & hit(addr, ADDR_MODE);
  wire control_wr   = wr_stb & hit(addr, ADDR_CONTROL);
  wire numer_wr     = wr_stb & hit(addr, ADDR_NUMER);
  wire denom_wr     = wr_stb & hit(addr, ADDR_DENOM);
  wire submode_wr   = wr_stb & hit(addr, ADDR_SUBMODE);
  wire window_wr    = wr_stb & hit(addr, ADDR_ERR_WINDOW);
  wire timeout_wr   = wr_stb & hit(addr, ADDR_ERR_TIMEOUT);
  wire route_wr     = wr_stb & hit(addr, ADDR_ROUTE_EN);

  // input conditioning settings, one short block per register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          special_en_q <= SPECIAL_EN_RESET;
    else if (special_wr) special_en_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         invert_q <= 32'h0000_0000;
    else if (invert_wr) invert_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)           force_en_q <= 32'h0000_0000;
    else if (force_en_wr) force_en_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)            force_val_q <= 32'h0000_0000;
    else if (force_val_wr) force_val_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         thresh_q <= 32'h0000_0000;
    else if (thresh_wr) thresh_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)        route_en_q <= 1'b0;
    else if (route_wr) route_en_q <= wdata[0]; // see RL22
  end

  // stepping and supervision settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)       mode_q <= 8'h00;
    else if (mode_wr) mode_q <= wdata[7:0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          control_q <= 32'h0000_0000;
    else if (control_wr) control_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)        numer_q <= NUMER_RESET;
    else if (numer_wr) numer_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)        denom_q <= DENOM_RESET;
    else if (denom_wr) denom_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          submode_q <= 1'b0;
    else if (submode_wr) submode_q <= wdata[0];
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)         err_window_q <= 32'h0000_0000;
    else if (window_wr) err_window_q <= wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)          err_timeout_q <= 32'h0000_0000;
    else if (timeout_wr) err_timeout_q <= wdata;
  end

  // mode decode
  wire mode_step  = (mode_q == MODE_STEP_DIR);   // see RL1
  wire mode_setup = (mode_q == MODE_AUTO_SETUP); // see RL9

  // conditioning: routing on leaves pins straight through
  wire [N_IN-1:0] raw        = pin_s2_q; // see RL20
  wire [N_IN-1:0] eff_fen    = route_en_q ? '0 : force_en_q[N_IN-1:0];
  wire [N_IN-1:0] eff_inv    = route_en_q ? '0 : invert_q[N_IN-1:0];
  wire [N_IN-1:0] eff_sen    = route_en_q ? '1 : special_en_q[N_IN-1:0];
  wire [N_IN-1:0] selected   = (eff_fen & force_val_q[N_IN-1:0])
                             | (~eff_fen & raw); // see RL19 RL23
  wire [N_IN-1:0] level      = selected ^ eff_inv; // see RL18 RL23
  wire [N_IN-1:0] special    = level & eff_sen; // see RL15 RL23

  // summary word
  logic [31:0] summary;
  always_comb begin
    summary = 32'h0000_0000;
    for (int i = 0; i < N_IN; i++) begin
      summary[LEVEL_BASE + i] = level[i]; // see RL13 RL14
    end
    // in stepping mode inputs 1 and 2 are clock/direction, not limits
    summary[0] = special[0] & ~mode_step; // see RL16 RL17
    summary[1] = special[1] & ~mode_step; // see RL16 RL17
    summary[2] = special[2];              // see RL16 RL17
  end

  // limit and home outputs from flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      neg_limit   <= 1'b0;
      pos_limit   <= 1'b0;
      home_switch <= 1'b0;
    end else begin
      neg_limit   <= summary[0];
      pos_limit   <= summary[1];
      home_switch <= summary[2];
    end
  end
  assign threshold_24v = thresh_q[N_IN-1:0]; // see RL21

  // clock/direction path ignores inversion
  step_if step_bus ();
  step_pulse_decoder u_decode (
    .clk     (clk),
    .rst_n   (rst_n),
    .enable  (mode_step),
    .submode (submode_q),
    .line_a  (selected[0]),
    .line_b  (selected[1]),
    .ev      (step_bus)
  ); // see RL18

  // step accumulation: numerator per pulse, fraction over denominator
  logic [31:0] pos_q;
  logic [31:0] frac_q;
  logic [31:0] frac_sum;
  logic [31:0] whole;
  logic [31:0] rem;
  always_comb begin
    frac_sum = frac_q + numer_q;
    whole    = (denom_q == 32'h0) ? numer_q : frac_sum / denom_q;
    rem      = (denom_q == 32'h0) ? 32'h0 : frac_sum % denom_q;
  end
  logic [31:0] pos_d;
  logic [31:0] frac_d;
  // next position and fraction, held between pulses
  always_comb begin
    pos_d  = pos_q;
    frac_d = frac_q;
    if (step_bus.step) begin
      frac_d = rem; // see RL4
      if (step_bus.dir_neg) pos_d = pos_q - whole; // see RL2
      else                  pos_d = pos_q + whole; // see RL2
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q  <= 32'h0000_0000;
      frac_q <= 32'h0000_0000;
    end else begin
      pos_q  <= pos_d;
      frac_q <= frac_d;
    end
  end
  assign step_position = pos_q;

  // tracking error supervision
  logic [31:0] err_mag;
  logic [31:0] err_cnt_q;
  logic [31:0] ms_cnt_q;
  logic        follow_err_q;
  always_comb begin
    err_mag = ($signed(pos_q - actual_position) < 0) ?
              (actual_position - pos_q) : (pos_q - actual_position);
  end
  wire outside = mode_step & (err_mag > err_window_q);
  wire ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q     <= 32'h0000_0000;
      err_cnt_q    <= 32'h0000_0000;
      follow_err_q <= 1'b0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
      if (!outside) begin
        err_cnt_q    <= 32'h0000_0000;
        follow_err_q <= 1'b0;
      end else if (ms_tick) begin
        if (err_cnt_q >= err_timeout_q) follow_err_q <= 1'b1; // see RL6
        else                            err_cnt_q    <= err_cnt_q + 32'h1;
      end
    end
  end

  // auto-setup
  logic indexed;
  logic aligned;
  auto_setup_seq #(.RUN_CYCLES(RUN_CYCLES)) u_setup (
    .clk        (clk),
    .rst_n      (rst_n),
    .active     (mode_setup),
    .start_bit  (control_q[CTRL_START_BIT]),
    .index_seen (idx_s2_q),
    .indexed    (indexed),
    .aligned    (aligned)
  ); // see RL10 RL11 RL12

  logic [31:0] status;
  always_comb begin
    status = 32'h0000_0000;
    status[STAT_INDEX_BIT]   = mode_setup & indexed; // see RL11
    status[STAT_ALIGNED_BIT] = aligned;              // see RL12
    status[STAT_FOLLOW_BIT]  = follow_err_q;         // see RL6
  end

  // read port
  logic [31:0] rd_mux;
  always_comb begin
    unique case (addr)
      ADDR_SPECIAL_EN:  rd_mux = special_en_q;
      ADDR_INVERT:      rd_mux = invert_q;
      ADDR_FORCE_EN:    rd_mux = force_en_q;
      ADDR_FORCE_VAL:   rd_mux = force_val_q;
      ADDR_RAW:         rd_mux = 32'(raw);
      ADDR_THRESH:      rd_mux = thresh_q;
      ADDR_SUMMARY:     rd_mux = summary;
      ADDR_MODE:        rd_mux = {24'h000000, mode_q};
      ADDR_CONTROL:     rd_mux = control_q;
      ADDR_STATUS:      rd_mux = status;
      ADDR_NUMER:       rd_mux = numer_q;
      ADDR_DENOM:       rd_mux = denom_q;
      ADDR_SUBMODE:     rd_mux = {31'h0, submode_q};
      ADDR_ERR_WINDOW:  rd_mux = err_window_q;
      ADDR_ERR_TIMEOUT: rd_mux = err_timeout_q;
      ADDR_ROUTE_EN:    rd_mux = {31'h0, route_en_q};
      ADDR_POSITION:    rd_mux = pos_q;
      ADDR_ACTUAL_POS:  rd_mux = actual_position;
      default:          rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)      rdata <= 32'h0000_0000;
    else if (rd_stb) rdata <= rd_mux;
    else             rdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// ==== sdc_far_side.sv ====
// far-side model: positioning controller pulses and switch levels
`timescale 1ns/100ps
`default_nettype none
module sdc_far_side (
  output logic [4:0] pins,
  output logic       index
);
  initial begin
    pins  = 5'h00;
    index = 1'b0;
  end
  // clock pulse on input 1, or either line in two-line submode
  task automatic pulse(input int ln);
    #7;
    pins[ln] = 1'b1;
    #240;
    pins[ln] = 1'b0;
    #760;
  endtask
  // direction change, then the settle gap
  task automatic set_dir(input logic v);
    #7;
    pins[1] = v;
    #35000;
  endtask
  task automatic set_sw(input logic [2:0] v);
    #7;
    pins[4:2] = v;
  endtask
  task automatic mark_index;
    #7;
    index = 1'b1;
    #200;
    index = 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== step_dir_input_conditioner_asserts.sv ====
// assertion checker for the step/direction input conditioner
`timescale 1ns/100ps
`default_nettype none
module step_dir_input_conditioner_asserts
  import sdc_pkg::*;
#(
  parameter int N_IN       = NUM_INPUTS,
  parameter int RUN_CYCLES = SETUP_CYCLES
) (
  input wire logic            clk,
  input wire logic            arst_n,
  input wire logic [N_IN-1:0] pin_in,
  input wire logic            index_pulse,
  input wire logic [31:0]     actual_position,
  input wire logic [4:0]      addr,
  input wire logic [31:0]     wdata,
  input wire logic            wr_stb,
  input wire logic            rd_stb,
  input wire logic [31:0]     rdata,
  input wire logic [N_IN-1:0] threshold_24v,
  input wire logic            neg_limit,
  input wire logic            pos_limit,
  input wire logic            home_switch,
  input wire logic [31:0]     step_position
);
  logic [31:0]     en_q, inv_q, fen_q, fv_q, num_q, den_q;
  logic [7:0]      mode_q;
  logic            route_q;
  logic [3:0]      quiet_q;
  logic [N_IN-1:0] pin_q;
  logic [N_IN-1:0] lvl;
  assign lvl = ((fen_q[N_IN-1:0] & fv_q[N_IN-1:0])
             | (~fen_q[N_IN-1:0] & pin_q)) ^ inv_q[N_IN-1:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // shadow of the written settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {en_q, inv_q, fen_q, fv_q} <= '0;
      {mode_q, route_q, quiet_q, pin_q} <= '0;
      num_q <= NUMER_RESET;
      den_q <= DENOM_RESET;
    end else begin
      pin_q   <= pin_in;
      quiet_q <= (wr_stb || pin_in != pin_q) ? 4'h0
               : quiet_q + {3'h0, quiet_q != 4'hF};
      if (wr_stb) begin
        case (addr)
          ADDR_SPECIAL_EN: en_q <= wdata;
          ADDR_INVERT:     inv_q <= wdata;
          ADDR_FORCE_EN:   fen_q <= wdata;
          ADDR_FORCE_VAL:  fv_q <= wdata;
          ADDR_MODE:       mode_q <= wdata[7:0];
          ADDR_NUMER:      num_q <= wdata;
          ADDR_DENOM:      den_q <= wdata;
          ADDR_ROUTE_EN:   route_q <= wdata[0];
          default: ;
        endcase
      end
    end
  end
  AST_THRESH: assert property (wr_stb && addr == ADDR_THRESH
    |=> threshold_24v == $past(wdata[N_IN-1:0]))
    else $error("threshold copy wrong");
  AST_RAW: assert property (rd_stb && addr == ADDR_RAW
    && quiet_q > 4'h4 |=> rdata[N_IN-1:0] == $past(pin_q))
    else $error("raw word wrong");
  AST_LEVEL: assert property (rd_stb && addr == ADDR_SUMMARY
    && quiet_q > 4'h4 && !route_q && mode_q != MODE_STEP_DIR
    |=> rdata[LEVEL_BASE+:N_IN] == $past(lvl))
    else $error("level bits wrong");
  AST_NEG_GATE: assert property (
    !en_q[0] && !route_q && quiet_q > 4'h4 |-> !neg_limit)
    else $error("negative limit not gated");
  AST_HOME_GATE: assert property (
    !en_q[2] && !route_q && quiet_q > 4'h4 |-> !home_switch)
    else $error("home switch not gated");
  AST_STEP_LIMITS: assert property (
    mode_q == MODE_STEP_DIR && $past(mode_q, 3) == MODE_STEP_DIR
    |-> !neg_limit && !pos_limit)
    else $error("limits active in stepping mode");
  AST_STEP_MODE: assert property (
    !$stable(step_position) |-> mode_q == MODE_STEP_DIR)
    else $error("step outside stepping mode");
  AST_STEP_SIZE: assert property (
    !$stable(step_position) && den_q == 32'h1
    |-> step_position - $past(step_position) == num_q
     || $past(step_position) - step_position == num_q)
    else $error("step width wrong");
  AST_INDEX_OFF: assert property (rd_stb && addr == ADDR_STATUS
    && mode_q != MODE_AUTO_SETUP |=> !rdata[STAT_INDEX_BIT])
    else $error("index flag outside auto-setup");
  cover property (!$stable(step_position));
  cover property (home_switch);
  cover property (rd_stb && addr == ADDR_STATUS ##1 rdata[STAT_ALIGNED_BIT]);
endmodule
bind step_dir_input_conditioner step_dir_input_conditioner_asserts #(
  .N_IN(N_IN), .RUN_CYCLES(RUN_CYCLES)
) u_asserts (
  .clk(clk), .arst_n(arst_n), .pin_in(pin_in), .index_pulse(index_pulse),
  .actual_position(actual_position), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .threshold_24v(threshold_24v), .neg_limit(neg_limit),
  .pos_limit(pos_limit), .home_switch(home_switch),
  .step_position(step_position)
);
`default_nettype wire

// ==== step_dir_input_conditioner_test.sv ====
// testbench for the step/direction input conditioner
`timescale 1ns/100ps
`default_nettype none
module step_dir_input_conditioner_test;
  import sdc_pkg::*;
  logic        clk, arst_n, index_pulse, wr_stb, rd_stb;
  logic        neg_limit, pos_limit, home_switch;
  logic [4:0]  pin_in, addr, threshold_24v;
  logic [31:0] wdata, rdata, step_position, got, act_pos;
  int          fail_count, total_checks, n;
  always #10 clk = ~clk;
  sdc_far_side far (.pins(pin_in), .index(index_pulse));
  step_dir_input_conditioner #(.RUN_CYCLES(40)) dut (
    .clk(clk), .arst_n(arst_n), .pin_in(pin_in), .index_pulse(index_pulse),
    .actual_position(act_pos), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .threshold_24v(threshold_24v),
    .neg_limit(neg_limit), .pos_limit(pos_limit),
    .home_switch(home_switch), .step_position(step_position)
  );
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    rd(a);
    chk(got & m, e);
  endtask
  initial begin
    {clk, arst_n, wr_stb, rd_stb, addr, wdata, act_pos} = '0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(ADDR_NUMER, NUMER_RESET);
    rdc(ADDR_DENOM, DENOM_RESET);
    rdc(ADDR_SPECIAL_EN, SPECIAL_EN_RESET);
    rdc(ADDR_STATUS, 32'h0, 32'h1400);
    wr(ADDR_RAW, 32'hFFFF_FFFF);
    rdc(ADDR_RAW, 32'h0);
    rdc(5'h1F, 32'h0);
    wr(ADDR_THRESH, 32'h15);
    chk({27'h0, threshold_24v}, 32'h15);
    rdc(ADDR_THRESH, 32'h15);
    far.set_sw(3'b111);
    repeat (6) @(posedge clk);
    rdc(ADDR_RAW, 32'h1C);
    rdc(ADDR_SUMMARY, 32'h001C_0000);
    wr(ADDR_SPECIAL_EN, 32'h7);
    rdc(ADDR_SUMMARY, 32'h001C_0004);
    chk({31'h0, home_switch}, 32'h1);
    wr(ADDR_INVERT, 32'h4);
    rdc(ADDR_SUMMARY, 32'h0018_0000);
    wr(ADDR_FORCE_EN, 32'h9);
    wr(ADDR_FORCE_VAL, 32'h1);
    rdc(ADDR_SUMMARY, 32'h0011_0001);
    chk({31'h0, neg_limit}, 32'h1);
    rdc(ADDR_RAW, 32'h1C);
    wr(ADDR_ROUTE_EN, 32'h1);
    rdc(ADDR_SUMMARY, 32'h001C_0004);
    wr(ADDR_ROUTE_EN, 32'h0);
    wr(ADDR_FORCE_EN, 32'h0);
    far.set_sw(3'b000);
    wr(ADDR_INVERT, 32'h3);
    chk({30'h0, neg_limit, pos_limit}, 32'h3);
    wr(ADDR_MODE, 32'hFF);
    chk({30'h0, neg_limit, pos_limit}, 32'h0);
    far.set_dir(1'b0);
    repeat (3) far.pulse(0);
    chk(step_position, 32'h180);
    wr(ADDR_NUMER, 32'h200);
    rdc(ADDR_NUMER, 32'h200);
    far.set_dir(1'b1);
    far.pulse(0);
    chk(step_position, 32'hFFFF_FF80);
    wr(ADDR_SUBMODE, 32'h1);
    far.set_dir(1'b0);
    far.pulse(1);
    far.pulse(1);
    far.pulse(0);
    chk(step_position, 32'hFFFF_FD80);
    wr(ADDR_ERR_WINDOW, 32'h10);
    act_pos <= 32'hFFFF_FD80;
    repeat (2) @(posedge clk);
    rdc(ADDR_STATUS, 32'h0, 32'h2000);
    @(posedge clk);
    act_pos <= 32'hFFFF_FE80;
    got = 32'h0;
    for (n = 0; n < 60 && got[STAT_FOLLOW_BIT] !== 1'b1; n++) begin
      repeat (1000) @(posedge clk);
      rd(ADDR_STATUS);
    end
    chk({31'h0, got[STAT_FOLLOW_BIT]}, 32'h1);
    @(posedge clk);
    act_pos <= 32'hFFFF_FD88;
    repeat (2) @(posedge clk);
    rdc(ADDR_STATUS, 32'h0, 32'h2000);
    wr(ADDR_CONTROL, 32'h10);
    wr(ADDR_MODE, 32'hFE);
    repeat (60) @(posedge clk);
    rdc(ADDR_STATUS, 32'h0, 32'h1000);
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_CONTROL, 32'h10);
    far.mark_index;
    got = 32'h0;
    for (n = 0; n < 200 && got[STAT_ALIGNED_BIT] !== 1'b1; n++) begin
      rd(ADDR_STATUS);
    end
    if (n == 200) fail_count++;
    else rdc(ADDR_STATUS, 32'h1400, 32'h1400);
    finish_test();
  end
endmodule
`default_nettype wire
